/* File: core/pcmsp_pkg.sv */
/*
  constants, register map and state type for the two pcm sample serial ports.
  assumes a single 50 mhz core clock and a synchronous active-high reset.
*/
// Behaviour
// R1 - rx idle-float bit: tristate else drive low
// R2 - rx enable runs clock; sync needs channel
// R3 - rx disabled: clock low, samples discarded
// R4 - rx disable mid-frame finishes frame first
// R5 - rx invert bit inverts clock; fixed while enabled
// R6 - tx master short sync, msb first
// R7 - two tx words or one, bypassed
// R8 - tx clock divide 2..256, zero means 256
// R9 - host picks tx clock >=32x integer ratio
// R10 - tx channel b select includes b word
// R11 - tx channel a select includes a word
// R12 - tx enable runs clock; sync needs channel
// R13 - tx disable holds clock low after frame
// R14 - tx invert bit inverts clock; fixed while enabled
// R15 - host writes zero to tx reserved bits
// R16 - rx master short sync, msb first
// R17 - rx clock divide 2..256, 50:50 duty; code keeps odd divides high one cycle longer than low, or low one cycle longer than high when inverted
// R18 - rx channel selects include or bypass words
// R19 - host picks rx clock >=32x integer ratio
// R20 - sync one bit wide, before first bit
package pcmsp_pkg;
  localparam logic [7:0] RX_DIV_ADDR   = 8'h40;
  localparam logic [7:0] RX_CTRL_ADDR  = 8'h41;
  localparam logic [7:0] TX_DIV_ADDR   = 8'h48;
  localparam logic [7:0] TX_CTRL_ADDR  = 8'h49;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         INV_BIT       = 0;
  localparam int         EN_BIT        = 1;
  localparam int         RX_FLOAT_BIT  = 2;
  localparam int         RX_SEL_A_BIT  = 3;
  localparam int         RX_SEL_B_BIT  = 4;
  localparam int         TX_SEL_A_BIT  = 2;
  localparam int         TX_SEL_B_BIT  = 3;
  localparam logic [7:0] RX_CTRL_MASK  = 8'h1f;
  localparam logic [7:0] TX_CTRL_MASK  = 8'h0f;
  localparam logic [5:0] LAST_BIT_ONE  = 6'h0f;
  localparam logic [5:0] LAST_BIT_TWO  = 6'h1f;
  localparam logic [7:0] DIV_ZERO_NM1  = 8'hff;
  localparam logic [7:0] DIV_MIN_NM1   = 8'h01;
  localparam logic [8:0] DIV_ZERO_N    = 9'h100;

  typedef enum logic [2:0] {
    PCMSP_IDLE  = 3'b001,
    PCMSP_SYNC  = 3'b010,
    PCMSP_SHIFT = 3'b100
  } pcmsp_state_t;
endpackage

/* File: core/pcmsp_ports.sv */
/*
  receive and transmit pcm serial ports, master mode, short frame sync.
  assumes register writes arrive as one-cycle strobes and that sample
  strobes from the channel filters are synchronous to core_clk.
*/
`timescale 1ns/1ps
module pcmsp_ports (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [15:0] rx_a_sample,
  input  wire logic [15:0] rx_b_sample,
  input  wire logic        rx_sample_valid,
  output logic             rx_bit_clock,
  output logic             rx_frame_sync,
  output logic             rx_data,
  output logic             rx_data_oe,
  input  wire logic        tx_sample_req,
  output logic             tx_bit_clock,
  output logic             tx_frame_sync,
  input  wire logic        tx_data,
  output logic [15:0]      tx_a_sample,
  output logic [15:0]      tx_b_sample,
  output logic             tx_a_valid,
  output logic             tx_b_valid
);
  logic [7:0] rx_div_q, rx_div_d, rx_ctrl_q, rx_ctrl_d;
  logic [7:0] tx_div_q, tx_div_d, tx_ctrl_q, tx_ctrl_d;

  always_comb begin
    rx_div_d  = rx_div_q;
    rx_ctrl_d = rx_ctrl_q;
    tx_div_d  = tx_div_q;
    tx_ctrl_d = tx_ctrl_q;
    if (reg_wr) begin
      if (reg_addr == pcmsp_pkg::RX_DIV_ADDR) begin
        rx_div_d = reg_wdata;
      end else if (reg_addr == pcmsp_pkg::RX_CTRL_ADDR) begin
        rx_ctrl_d = reg_wdata & pcmsp_pkg::RX_CTRL_MASK;
      end else if (reg_addr == pcmsp_pkg::TX_DIV_ADDR) begin
        tx_div_d = reg_wdata;
      end else if (reg_addr == pcmsp_pkg::TX_CTRL_ADDR) begin
        tx_ctrl_d = reg_wdata & pcmsp_pkg::TX_CTRL_MASK; // R15
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_div_q  <= pcmsp_pkg::REG_RESET;
      rx_ctrl_q <= pcmsp_pkg::REG_RESET;
      tx_div_q  <= pcmsp_pkg::REG_RESET;
      tx_ctrl_q <= pcmsp_pkg::REG_RESET;
    end else begin
      rx_div_q  <= rx_div_d;
      rx_ctrl_q <= rx_ctrl_d;
      tx_div_q  <= tx_div_d;
      tx_ctrl_q <= tx_ctrl_d;
    end
  end

  logic       rx_en, tx_en;
  logic [1:0] rx_sel, tx_sel;
  assign rx_en  = rx_ctrl_q[pcmsp_pkg::EN_BIT];
  assign tx_en  = tx_ctrl_q[pcmsp_pkg::EN_BIT];
  assign rx_sel = {rx_ctrl_q[pcmsp_pkg::RX_SEL_A_BIT], rx_ctrl_q[pcmsp_pkg::RX_SEL_B_BIT]};
  assign tx_sel = {tx_ctrl_q[pcmsp_pkg::TX_SEL_A_BIT], tx_ctrl_q[pcmsp_pkg::TX_SEL_B_BIT]};

  // index 0 is the receive port, index 1 the transmit port
  wire [1:0][7:0] div_w;
  wire [1:0]      en_w, inv_w, busy_w, end_w, mid_w, run_w, bclk_w;
  assign div_w = {tx_div_q, rx_div_q};
  assign en_w  = {tx_en, rx_en};
  assign inv_w = {tx_ctrl_q[pcmsp_pkg::INV_BIT], rx_ctrl_q[pcmsp_pkg::INV_BIT]};

  for (genvar g = 0; g < 2; g++) begin : g_bclk
    logic [7:0] cnt_q, cnt_d, nm1;
    logic       run_q, run_d, clk_q, clk_d;
    always_comb begin
      nm1 = (div_w[g] == 8'h00) ? pcmsp_pkg::DIV_ZERO_NM1 :                 // R8 R17
            (div_w[g] == 8'h01) ? pcmsp_pkg::DIV_MIN_NM1 : div_w[g] - 8'h01;
      run_d = run_q;
      cnt_d = cnt_q;
      if (!run_q) begin
        run_d = en_w[g];                                                    // R2 R12
        cnt_d = 8'h00;
      end else if (cnt_q >= nm1) begin
        run_d = en_w[g] | busy_w[g];                                        // R4 R13
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
      // a stopped clock is low whatever the invert bit says
      clk_d = run_d & ((cnt_d <= (nm1 >> 1)) ^ inv_w[g]);                   // R3 R5 R14
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        cnt_q <= 8'h00;
        run_q <= 1'b0;
        clk_q <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        run_q <= run_d;
        clk_q <= clk_d;
      end
    end
    assign end_w[g]  = run_q & (cnt_q >= nm1);
    assign mid_w[g]  = run_q & (cnt_q == (nm1 >> 1));
    assign run_w[g]  = run_q;
    assign bclk_w[g] = clk_q;
  end

  assign rx_bit_clock = bclk_w[0];
  assign tx_bit_clock = bclk_w[1];

  // receive port
  pcmsp_pkg::pcmsp_state_t rx_st_q, rx_st_d;
  logic [31:0] rx_sr_q, rx_sr_d;
  logic [15:0] rx_a_q, rx_a_d, rx_b_q, rx_b_d;
  logic [5:0]  rx_bit_q, rx_bit_d;
  logic [1:0]  rx_fsel_q, rx_fsel_d;
  logic        rx_pend_q, rx_pend_d, rx_dat_q, rx_dat_d, rx_oe_q, rx_oe_d, rx_fs_q, rx_fs_d, rx_go;

  always_comb begin
    rx_st_d   = rx_st_q;
    rx_sr_d   = rx_sr_q;
    rx_a_d    = rx_a_q;
    rx_b_d    = rx_b_q;
    rx_bit_d  = rx_bit_q;
    rx_fsel_d = rx_fsel_q;
    rx_pend_d = rx_pend_q;
    rx_dat_d  = rx_dat_q;
    rx_go     = 1'b0;
    if (end_w[0]) begin
      case (rx_st_q)
        pcmsp_pkg::PCMSP_IDLE: begin
          rx_go = 1'b1;
        end
        pcmsp_pkg::PCMSP_SYNC: begin
          rx_st_d  = pcmsp_pkg::PCMSP_SHIFT;                                // R20
          rx_dat_d = rx_sr_q[31];                                           // R16
          rx_sr_d  = {rx_sr_q[30:0], 1'b0};
          rx_bit_d = 6'h00;
        end
        pcmsp_pkg::PCMSP_SHIFT: begin
          if (rx_bit_q == ((rx_fsel_q == 2'b11) ? pcmsp_pkg::LAST_BIT_TWO : pcmsp_pkg::LAST_BIT_ONE)) begin
            rx_st_d  = pcmsp_pkg::PCMSP_IDLE;
            rx_dat_d = 1'b0;
            rx_go    = 1'b1;                                                // back-to-back frames
          end else begin
            rx_dat_d = rx_sr_q[31];
            rx_sr_d  = {rx_sr_q[30:0], 1'b0};
            rx_bit_d = rx_bit_q + 6'h01;
          end
        end
        default: begin
          rx_st_d = pcmsp_pkg::PCMSP_IDLE;
        end
      endcase
    end
    if (rx_go && rx_pend_q && rx_en && (rx_sel != 2'b00)) begin            // R2
      rx_st_d   = pcmsp_pkg::PCMSP_SYNC;
      rx_pend_d = 1'b0;
      rx_fsel_d = rx_sel;
      rx_sr_d   = (rx_sel == 2'b11) ? {rx_a_q, rx_b_q} :                   // R18
                  rx_sel[1] ? {rx_a_q, 16'h0000} : {rx_b_q, 16'h0000};
    end
    // a new sample beats the frame start that consumes the old one
    if (!rx_en) begin
      rx_pend_d = 1'b0;                                                     // R3
    end else if (rx_sample_valid) begin
      rx_pend_d = 1'b1;
      rx_a_d    = rx_a_sample;
      rx_b_d    = rx_b_sample;
    end
    rx_oe_d = !rx_ctrl_q[pcmsp_pkg::RX_FLOAT_BIT] | (rx_st_d == pcmsp_pkg::PCMSP_SHIFT); // R1
    rx_fs_d = (rx_st_d == pcmsp_pkg::PCMSP_SYNC);                                        // R20
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_st_q   <= pcmsp_pkg::PCMSP_IDLE;
      rx_sr_q   <= 32'h00000000;
      rx_a_q    <= 16'h0000;
      rx_b_q    <= 16'h0000;
      rx_bit_q  <= 6'h00;
      rx_fsel_q <= 2'b00;
      rx_pend_q <= 1'b0;
      rx_dat_q  <= 1'b0;
      rx_oe_q   <= 1'b1;
      rx_fs_q   <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_sr_q   <= rx_sr_d;
      rx_a_q    <= rx_a_d;
      rx_b_q    <= rx_b_d;
      rx_bit_q  <= rx_bit_d;
      rx_fsel_q <= rx_fsel_d;
      rx_pend_q <= rx_pend_d;
      rx_dat_q  <= rx_dat_d;
      rx_oe_q   <= rx_oe_d;
      rx_fs_q   <= rx_fs_d;
    end
  end

  assign rx_data       = rx_dat_q;
  assign rx_data_oe    = rx_oe_q;
  assign rx_frame_sync = rx_fs_q;
  assign busy_w[0]     = (rx_st_d != pcmsp_pkg::PCMSP_IDLE);

  // transmit port
  pcmsp_pkg::pcmsp_state_t tx_st_q, tx_st_d;
  logic [31:0] tx_sr_q, tx_sr_d;
  logic [15:0] tx_a_q, tx_a_d, tx_b_q, tx_b_d;
  logic [5:0]  tx_bit_q, tx_bit_d;
  logic [1:0]  tx_fsel_q, tx_fsel_d;
  logic        tx_pend_q, tx_pend_d, tx_av_q, tx_av_d, tx_bv_q, tx_bv_d, tx_fs_q, tx_fs_d, tx_go;

  always_comb begin
    tx_st_d   = tx_st_q;
    tx_sr_d   = tx_sr_q;
    tx_a_d    = tx_a_q;
    tx_b_d    = tx_b_q;
    tx_bit_d  = tx_bit_q;
    tx_fsel_d = tx_fsel_q;
    tx_pend_d = tx_pend_q;
    tx_av_d   = 1'b0;
    tx_bv_d   = 1'b0;
    tx_go     = 1'b0;
    if (mid_w[1] && tx_st_q == pcmsp_pkg::PCMSP_SHIFT) begin
      tx_sr_d = {tx_sr_q[30:0], tx_data};                                   // R6
    end
    if (end_w[1]) begin
      case (tx_st_q)
        pcmsp_pkg::PCMSP_IDLE: begin
          tx_go = 1'b1;
        end
        pcmsp_pkg::PCMSP_SYNC: begin
          tx_st_d  = pcmsp_pkg::PCMSP_SHIFT;                                // R20
          tx_bit_d = 6'h00;
        end
        pcmsp_pkg::PCMSP_SHIFT: begin
          if (tx_bit_q == ((tx_fsel_q == 2'b11) ? pcmsp_pkg::LAST_BIT_TWO : pcmsp_pkg::LAST_BIT_ONE)) begin
            tx_st_d = pcmsp_pkg::PCMSP_IDLE;
            tx_go   = 1'b1;
            if (tx_fsel_q == 2'b11) begin                                   // R7
              tx_a_d  = tx_sr_q[31:16];
              tx_b_d  = tx_sr_q[15:0];
              tx_av_d = 1'b1;
              tx_bv_d = 1'b1;
            end else if (tx_fsel_q[1]) begin                                // R11
              tx_a_d  = tx_sr_q[15:0];
              tx_av_d = 1'b1;
            end else begin                                                  // R10
              tx_b_d  = tx_sr_q[15:0];
              tx_bv_d = 1'b1;
            end
          end else begin
            tx_bit_d = tx_bit_q + 6'h01;
          end
        end
        default: begin
          tx_st_d = pcmsp_pkg::PCMSP_IDLE;
        end
      endcase
    end
    if (tx_go && tx_pend_q && tx_en && (tx_sel != 2'b00)) begin            // R12
      tx_st_d   = pcmsp_pkg::PCMSP_SYNC;
      tx_pend_d = 1'b0;
      tx_fsel_d = tx_sel;
    end
    if (!tx_en) begin
      tx_pend_d = 1'b0;
    end else if (tx_sample_req) begin
      tx_pend_d = 1'b1;
    end
    tx_fs_d = (tx_st_d == pcmsp_pkg::PCMSP_SYNC);                           // R20
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_st_q   <= pcmsp_pkg::PCMSP_IDLE;
      tx_sr_q   <= 32'h00000000;
      tx_a_q    <= 16'h0000;
      tx_b_q    <= 16'h0000;
      tx_bit_q  <= 6'h00;
      tx_fsel_q <= 2'b00;
      tx_pend_q <= 1'b0;
      tx_av_q   <= 1'b0;
      tx_bv_q   <= 1'b0;
      tx_fs_q   <= 1'b0;
    end else begin
      tx_st_q   <= tx_st_d;
      tx_sr_q   <= tx_sr_d;
      tx_a_q    <= tx_a_d;
      tx_b_q    <= tx_b_d;
      tx_bit_q  <= tx_bit_d;
      tx_fsel_q <= tx_fsel_d;
      tx_pend_q <= tx_pend_d;
      tx_av_q   <= tx_av_d;
      tx_bv_q   <= tx_bv_d;
      tx_fs_q   <= tx_fs_d;
    end
  end

  assign tx_a_sample   = tx_a_q;
  assign tx_b_sample   = tx_b_q;
  assign tx_a_valid    = tx_av_q;
  assign tx_b_valid    = tx_bv_q;
  assign tx_frame_sync = tx_fs_q;
  assign busy_w[1]     = (tx_st_d != pcmsp_pkg::PCMSP_IDLE);

  // helper: cycles between rising edges of the transmit clock
  logic [8:0] tx_per_q, tx_per_d, tx_n9;
  logic       tx_seen_q, tx_seen_d, tx_prev_q, tx_rise;
  always_comb begin
    tx_rise   = tx_bit_clock & !tx_prev_q;
    tx_per_d  = tx_rise ? 9'h001 : tx_per_q + 9'h001;
    tx_seen_d = run_w[1] & (tx_rise | tx_seen_q);
    tx_n9     = (tx_div_q == 8'h00) ? pcmsp_pkg::DIV_ZERO_N : {1'b0, tx_div_q};
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_per_q  <= 9'h000;
      tx_seen_q <= 1'b0;
      tx_prev_q <= 1'b0;
    end else begin
      tx_per_q  <= tx_per_d;
      tx_seen_q <= tx_seen_d;
      tx_prev_q <= tx_bit_clock;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rx_float_idle: assert property (($past(rx_ctrl_q[pcmsp_pkg::RX_FLOAT_BIT]) && rx_st_q != pcmsp_pkg::PCMSP_SHIFT)
    |-> !rx_data_oe) else $error("rx data driven between frames while float set"); // R1
  a_rx_shift_drive: assert property (rx_st_q == pcmsp_pkg::PCMSP_SHIFT |-> rx_data_oe)
    else $error("rx data not driven during frame"); // R1
  a_rx_sync_gate: assert property ($rose(rx_frame_sync) |-> $past(rx_en) && $past(rx_sel) != 2'b00)
    else $error("rx frame sync without port and channel enabled"); // R2
  a_rx_clk_stop: assert property (!run_w[0] |-> !rx_bit_clock && !rx_frame_sync)
    else $error("rx clock toggling while stopped"); // R3
  a_rx_discard: assert property (!rx_en |=> !rx_pend_q)
    else $error("rx sample kept while disabled"); // R3
  a_rx_finish: assert property (rx_st_q != pcmsp_pkg::PCMSP_IDLE |-> run_w[0])
    else $error("rx clock stopped inside a frame"); // R4
  a_sync_width: assert property ($rose(tx_frame_sync) |-> (tx_frame_sync && tx_st_q == pcmsp_pkg::PCMSP_SYNC) [*2])
    else $error("tx sync shorter than two cycles"); // R20
  a_sync_then_data: assert property ($fell(rx_frame_sync) |-> rx_st_q == pcmsp_pkg::PCMSP_SHIFT && rx_data_oe)
    else $error("rx data does not follow sync"); // R20
  a_tx_divide: assert property ((tx_rise && tx_seen_q && $stable(tx_div_q) && tx_div_q != 8'h01)
    |-> tx_per_q == tx_n9) else $error("tx clock period differs from divide value"); // R8
  a_tx_sync_gate: assert property ($rose(tx_frame_sync) |-> $past(tx_en) && $past(tx_sel) != 2'b00)
    else $error("tx frame sync without port and channel enabled"); // R12
  a_tx_clk_stop: assert property (!run_w[1] |-> !tx_bit_clock && !tx_frame_sync)
    else $error("tx clock not low while stopped"); // R13
  a_tx_words: assert property ((tx_a_valid && !tx_b_valid) |-> $past(tx_fsel_q) == 2'b10)
    else $error("tx single a word with wrong selection"); // R7
  a_tx_b_only: assert property ((tx_b_valid && !tx_a_valid) |-> $past(tx_fsel_q) == 2'b01)
    else $error("tx single b word with wrong selection"); // R10

  c_rx_both: cover property (rx_frame_sync && rx_fsel_q == 2'b11);
  c_tx_b2b: cover property (tx_a_valid ##[1:40] tx_frame_sync);
  c_rx_stop_mid: cover property (rx_st_q == pcmsp_pkg::PCMSP_SHIFT && !rx_en);
endmodule

/* File: bench/pcmsp_host_model.sv */
/*
  host dsp slave model for both pcm ports: feeds tx words, captures rx words.
  assumes non-inverted bit clocks during frames and core_clk-synchronous port outputs.
*/
`timescale 1ns/1ps
module pcmsp_host_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [31:0] tx_words,
  input  wire logic [5:0]  rx_len,
  input  wire logic        tx_bit_clock,
  input  wire logic        tx_frame_sync,
  output logic             tx_data,
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_data,
  output logic [31:0]      rx_word,
  output logic [5:0]       rx_count
);
  logic [31:0] tx_sh_q;
  logic        tx_clk_q;
  logic        rx_clk_q;
  logic        rx_busy_q;
  // the device samples where its clock falls, so the next bit goes out only after that fall
  assign tx_data = tx_sh_q[31];
  always_ff @(posedge core_clk) begin
    tx_clk_q <= tx_bit_clock;
    rx_clk_q <= rx_bit_clock;
    if (rst) begin
      tx_sh_q   <= 32'h5a5a_5a5a;
      rx_busy_q <= 1'b0;
      rx_word   <= 32'h0000_0000;
      rx_count  <= 6'h00;
    end else begin
      if (tx_clk_q && !tx_bit_clock) begin
        if (tx_frame_sync) begin
          tx_sh_q <= tx_words;
        end else begin
          tx_sh_q <= {tx_sh_q[30:0], ~tx_sh_q[0]}; // line keeps changing once the frame is over
        end
      end
      if (rx_clk_q && !rx_bit_clock) begin
        if (rx_frame_sync) begin
          rx_busy_q <= 1'b1;
          rx_count  <= 6'h00;
        end else if (rx_busy_q) begin
          rx_word   <= {rx_word[30:0], rx_data};
          rx_count  <= rx_count + 6'h01;
          rx_busy_q <= (rx_count + 6'h01) != rx_len;
        end
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
/*
  self-checking bench for the pcm serial ports against the host model.
  assumes a 50 mhz core clock and the register map of the design package.
*/
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0;
  logic        rx_sample_valid = 1'b0, tx_sample_req = 1'b0, fs_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] rx_a_sample = 16'h0000, rx_b_sample = 16'h0000, tx_a_sample, tx_b_sample;
  logic        rx_bit_clock, rx_frame_sync, rx_data, rx_data_oe, tx_data;
  logic        tx_bit_clock, tx_frame_sync, tx_a_valid, tx_b_valid;
  logic [31:0] tx_words = 32'h0000_0000, rx_word;
  logic [5:0]  rx_len = 6'h10, rx_count;
  wire         rx_line;
  int          n_errors = 0, n_tests = 0;

  // no pull on the released line: the model sees the inverse, so a sample taken off-frame shows up
  assign rx_line = rx_data_oe ? rx_data : ~rx_data;
  always #10ns core_clk = ~core_clk;

  pcmsp_ports i_pcmsp_ports (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rx_a_sample(rx_a_sample), .rx_b_sample(rx_b_sample),
    .rx_sample_valid(rx_sample_valid), .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .rx_data(rx_data), .rx_data_oe(rx_data_oe), .tx_sample_req(tx_sample_req),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync), .tx_data(tx_data),
    .tx_a_sample(tx_a_sample), .tx_b_sample(tx_b_sample), .tx_a_valid(tx_a_valid), .tx_b_valid(tx_b_valid));
  pcmsp_host_model i_pcmsp_host_model (.core_clk(core_clk), .rst(rst), .tx_words(tx_words),
    .rx_len(rx_len), .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync), .tx_data(tx_data),
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync), .rx_data(rx_line),
    .rx_word(rx_word), .rx_count(rx_count));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2ns;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  function automatic logic probe(input int w);
    case (w)
      0: return tx_a_valid | tx_b_valid;
      1: return rx_frame_sync;
      default: return rx_count == rx_len;
    endcase
  endfunction
  task automatic wait_on(input int w, input int lim);
    for (int i = 0; i < lim && probe(w) !== 1'b1; i++) tick(1);
    if (probe(w) !== 1'b1) begin
      chk("bounded wait", 32'h0, 32'h1);
      conclude();
    end
  endtask
  // a pulsing strobe is pointless if the port under test never runs, so the wait is bounded
  task automatic until_clk(input logic [7:0] a, input logic inv, input logic v, output int cnt);
    for (cnt = 0; cnt < 600 && (((a == pcmsp_pkg::TX_DIV_ADDR) ? tx_bit_clock : rx_bit_clock) ^ inv) !== v;
         cnt++) begin
      tick(1);
      fs_seen |= rx_frame_sync | tx_frame_sync;
    end
    if (cnt == 600) begin
      chk("bit clock level", 32'h0, {31'h0, v});
      conclude();
    end
  endtask

  task automatic s_reset();
    chk("idle pins", {rx_bit_clock, tx_bit_clock, rx_frame_sync, tx_frame_sync, rx_data, rx_data_oe,
        tx_a_valid, tx_b_valid}, 32'h04);
  endtask
  task automatic s_clock(input logic [7:0] a, input logic [7:0] div, input logic inv);
    int n, hi, lo, i;
    n = (div == 8'h00) ? 256 : (div == 8'h01) ? 2 : int'(div);
    wr(a, div);
    wr(a + 8'h01, {6'h00, 1'b1, inv});
    rx_sample_valid = 1'b1;
    tx_sample_req = 1'b1;
    tick(1);
    rx_sample_valid = 1'b0;
    tx_sample_req = 1'b0;
    fs_seen = 1'b0;
    until_clk(a, inv, 1'b0, i);
    until_clk(a, inv, 1'b1, i);
    until_clk(a, inv, 1'b0, hi);
    until_clk(a, inv, 1'b1, lo);
    chk("bit clock high", hi, (n - 1) / 2 + 1);
    chk("bit clock period", hi + lo, n);
    chk("sync without channel", fs_seen, 1'b0);
    // the invert bit stays put in the write that disables the port
    wr(a + 8'h01, {7'h00, inv});
    tick(n + 4);
    chk("stopped clock", (a == pcmsp_pkg::TX_DIV_ADDR) ? tx_bit_clock : rx_bit_clock, 1'b0);
  endtask
  task automatic s_discard();
    logic seen;
    seen = 1'b0;
    wr(pcmsp_pkg::RX_DIV_ADDR, 8'h02);
    wr(8'h42, 8'hff);
    rx_sample_valid = 1'b1;
    tick(1);
    rx_sample_valid = 1'b0;
    repeat (8) begin tick(1); seen |= rx_bit_clock; end
    chk("rx clock while off", seen, 1'b0);
    wr(pcmsp_pkg::RX_CTRL_ADDR, 8'h0a);
    repeat (20) begin tick(1); seen |= rx_frame_sync; end
    chk("rx sync after discard", seen, 1'b0);
    wr(pcmsp_pkg::RX_CTRL_ADDR, 8'h00);
    tick(8);
  endtask
  task automatic s_tx(input logic [1:0] sel, input logic drop);
    tx_words = {16'h9b31 ^ {14'h0, sel}, 16'h6e0d};
    wr(pcmsp_pkg::TX_DIV_ADDR, 8'h02);
    wr(pcmsp_pkg::TX_CTRL_ADDR, {4'h0, sel, 2'b10});
    tx_sample_req = 1'b1;
    tick(1);
    tx_sample_req = 1'b0;
    if (drop) begin
      tick(8);
      wr(pcmsp_pkg::TX_CTRL_ADDR, 8'h00);
    end
    wait_on(0, 200);
    chk("tx valids", {tx_a_valid, tx_b_valid}, {sel[0], sel[1]});
    if (sel[0]) chk("tx word a", tx_a_sample, tx_words[31:16]);
    if (sel[1]) chk("tx word b", tx_b_sample, sel[0] ? tx_words[15:0] : tx_words[31:16]);
    tick(1);
    chk("tx valid pulse", {tx_a_valid, tx_b_valid}, 2'b00);
    if (drop) begin
      tick(4);
      chk("tx clock after drop", tx_bit_clock, 1'b0);
    end
    wr(pcmsp_pkg::TX_CTRL_ADDR, 8'h00);
    tick(6);
  endtask
  task automatic s_rx(input logic [1:0] sel, input logic flt);
    logic [31:0] exp, mask;
    rx_len = (sel == 2'b11) ? 6'h20 : 6'h10;
    rx_a_sample = 16'h8e17;
    rx_b_sample = 16'h71c2 ^ {14'h0, sel};
    exp = (sel == 2'b11) ? {rx_a_sample, rx_b_sample} : {16'h0, sel[0] ? rx_a_sample : rx_b_sample};
    mask = (sel == 2'b11) ? 32'hffff_ffff : 32'h0000_ffff;
    wr(pcmsp_pkg::RX_DIV_ADDR, 8'h03);
    wr(pcmsp_pkg::RX_CTRL_ADDR, {3'h0, sel, flt, 2'b10});
    rx_sample_valid = 1'b1;
    tick(1);
    rx_sample_valid = 1'b0;
    wait_on(1, 40);
    tick(8);
    wait_on(2, 200);
    chk("rx word", rx_word & mask, exp);
    tick(5);
    chk("rx line idle", {rx_data_oe, rx_data}, {~flt, 1'b0});
    wr(pcmsp_pkg::RX_CTRL_ADDR, 8'h00);
    tick(8);
  endtask

  initial begin
    tick(20);
    rst = 1'b0;
    s_reset();
    s_discard();
    s_clock(pcmsp_pkg::TX_DIV_ADDR, 8'h00, 1'b0);
    s_clock(pcmsp_pkg::TX_DIV_ADDR, 8'h03, 1'b1);
    s_clock(pcmsp_pkg::TX_DIV_ADDR, 8'h02, 1'b0);
    s_clock(pcmsp_pkg::RX_DIV_ADDR, 8'h05, 1'b1);
    s_clock(pcmsp_pkg::RX_DIV_ADDR, 8'h01, 1'b0);
    s_clock(pcmsp_pkg::RX_DIV_ADDR, 8'h00, 1'b0);
    s_tx(2'b11, 1'b0);
    s_tx(2'b01, 1'b0);
    s_tx(2'b10, 1'b0);
    s_tx(2'b11, 1'b1);
    s_rx(2'b11, 1'b1);
    s_rx(2'b01, 1'b0);
    s_rx(2'b10, 1'b1);
    conclude();
  end
endmodule
